/* line_pads.sv */
// line_pads.sv: far-side model of the two digital line pins
// assumes: weak pull-down on both lines; device drive wins over the outside source
`timescale 1ns/1ns
module line_pads (
    input  wire logic [1:0] line_out_i,  // device drive levels
    input  wire logic [1:0] line_oe_i,   // device drive enables
    input  wire logic [1:0] ext_en_i,    // outside source enables
    input  wire logic [1:0] ext_lvl_i,   // outside source levels
    output logic      [1:0] line_in_o    // resolved pin levels
);
    // a released line with no outside source enabled falls to the pull-down, never keeps a stale level
    always_comb begin
        line_in_o = (line_oe_i & line_out_i) | (~line_oe_i & ext_en_i & ext_lvl_i);
    end
endmodule

/* sensor_system_control_regs_tb_top.sv */
// sensor_system_control_regs_tb_top.sv: self-checking bench for the register bank
// assumes: 50 MHz clock, all command durations set to 20 cycles
`timescale 1ns/1ns
module sensor_system_control_regs_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;    // clock, reset, strobes
    logic [6:0] addr = 7'h0;                                 // register address
    logic [15:0] wd = 16'h0, rdata;                          // bus data
    logic [1:0] xen = 2'h0, xl = 2'h0, lin, lout, loe;       // line pins
    logic busy, trig, ste;                                   // status outputs
    logic xe = 1'b0, xb = 1'b0, cap = 1'b0;                  // frame end, bad length, capture
    localparam int unsigned CYC = 20;                        // shortened command time
    sys_ctrl_pkg::core_status_s core = '0;                   // core pulses
    sys_ctrl_pkg::core_cmd_s cmd;                            // command pulses
    int err_count = 0, num_checks = 0;                       // tallies
    always #10 clk = ~clk;
    sys_ctrl_regs #(.RESTORE_NC(CYC), .RESTORE_C(CYC), .COPY_NC(CYC), .COPY_C(CYC),
        .POINTER_CYC(CYC), .CLRBUF_CYC(CYC), .SWRST_CYC(CYC), .FTEST_CYC(CYC), .CLRDIAG_CYC(CYC),
        .FACTORY_CYC(CYC), .STEST_CYC(CYC), .NULL_CYC(CYC)) dut (.sys_clk_i(clk), .rst_n_i(rst_n),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
        .xfer_end_i(xe), .xfer_bad_len_i(xb), .capture_flash_i(1'b0), .capturing_i(cap),
        .core_i(core), .cmd_o(cmd), .cmd_busy_o(busy), .trigger_o(trig), .self_test_en_o(ste),
        .line_in_i(lin), .line_out_o(lout), .line_oe_o(loe));
    line_pads pads (.line_out_i(lout), .line_oe_i(loe), .ext_en_i(xen), .ext_lvl_i(xl),
        .line_in_o(lin));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one-cycle strobes, changed just after an edge
    task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // busy must show, then clear within a bounded wait
    task automatic run_cmd(input int b);
        int n;
        wr_reg(7'h3e, 16'h1 << b);
        repeat (2) @(posedge clk);
        #1 chk({14'h0, busy, lout[0]}, 16'h3);
        for (n = 0; n < 60 && busy !== 1'b0; n++) @(posedge clk);
        if (n == 60) begin
            err_count++;
            $display("FAIL %0t command never finished", $time);
            end_of_test();
        end
    endtask
    task automatic t_cmds;
        int b[9] = '{13, 12, 10, 8, 7, 5, 4, 2, 0};
        rd_chk(7'h36, 16'h000f);
        rd_chk(7'h3c, 16'h0000);
        rd_chk(7'h40, 16'h0000);
        foreach (b[i]) run_cmd(b[i]);
        wr_reg(7'h3e, 16'hc240);
        repeat (3) @(posedge clk);
        #1 chk({15'h0, busy}, 16'h0);
        $display("commands done");
    endtask
    task automatic t_diag;
        @(posedge clk);
        core.supply_low <= 1'b1;
        core.supply_high <= 1'b1;
        {xe, xb, cap} <= 3'h7;
        @(posedge clk);
        core <= '0;
        {xe, xb, cap} <= 3'h0;
        rd_chk(7'h3c, 16'h001b);
        rd_chk(7'h3c, 16'h001b);
        run_cmd(4);
        rd_chk(7'h3c, 16'h0000);
        core.selftest_fail <= 1'b1;
        run_cmd(2);
        core.selftest_fail <= 1'b0;
        rd_chk(7'h3c, 16'h0020);
        $display("flags done");
    endtask
    task automatic t_lines;
        logic got;
        wr_reg(7'h36, 16'h0000);
        wr_reg(7'h32, 16'h0101);
        xen <= 2'h2;
        xl <= 2'h2;
        repeat (3) @(posedge clk);
        #1 chk({13'h0, loe, lout[0]}, 16'h3);
        rd_chk(7'h32, 16'h0103);
        wr_reg(7'h34, 16'h0100);
        repeat (3) @(posedge clk);
        #1 chk({15'h0, ste}, 16'h1);
        wr_reg(7'h36, 16'h002f);
        xl <= 2'h0;
        // a too-short pulse, then one above the minimum width
        for (int w = 20; w < 200; w += 120) begin
            got = 1'b0;
            repeat (5) @(posedge clk);
            xl <= 2'h2;
            repeat (w) @(posedge clk);
            xl <= 2'h0;
            repeat (10) @(posedge clk) got |= trig;
            chk({15'h0, got}, {15'h0, w > 130});
        end
        wr_reg(7'h36, 16'h001f);
        core.alarm_hit <= 4'h1;
        @(posedge clk);
        core <= '0;
        repeat (3) @(posedge clk);
        #1 chk({15'h0, lout[1]}, 16'h1);
        run_cmd(4);
        #1 chk({15'h0, lout[1]}, 16'h0);
        run_cmd(3);
        rd_chk(7'h36, 16'h000f);
        $display("lines done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_cmds();
        t_diag();
        t_lines();
        end_of_test();
    end
endmodule

/* sys_ctrl_params.svh */
// sys_ctrl_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the register bank only, 50 MHz system clock
`ifndef SYS_CTRL_PARAMS_SVH
`define SYS_CTRL_PARAMS_SVH

// ------------------------------------------------------------
// register byte addresses (lower byte of each 16-bit register)
// ------------------------------------------------------------
`define ADDR_LINE_GPIO_CONTROL    7'h32
`define ADDR_MISC_CONTROL        7'h34
`define ADDR_LINE_FUNCTION_CFG   7'h36
`define ADDR_DIAGNOSTIC_FLAGS    7'h3c
`define ADDR_GLOBAL_COMMAND      7'h3e
`define ADDR_LOT_CODE_LOW        7'h52
`define ADDR_LOT_CODE_HIGH       7'h54
`define ADDR_PRODUCT_CODE        7'h56

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_LINE_FUNCTION_CFG    16'h000f
`define RST_LINE_GPIO_CONTROL    16'h0000
`define RST_MISC_CONTROL         16'h0000
`define RST_DIAGNOSTIC_FLAGS     16'h0000

// ------------------------------------------------------------
// command bit positions
// ------------------------------------------------------------
`define CMD_RESTORE_FLASH        13
`define CMD_COPY_FLASH           12
`define CMD_CAPTURE_TOGGLE       11
`define CMD_POINTER_RESET        10
`define CMD_CLEAR_BUFFERS        8
`define CMD_SOFT_RESET           7
`define CMD_FLASH_TEST           5
`define CMD_CLEAR_DIAG           4
`define CMD_FACTORY_RESTORE      3
`define CMD_SELF_TEST            2
`define CMD_POWER_DOWN           1
`define CMD_AUTONULL             0
`define CMD_VALID_MASK           16'h3dbf

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DIAG_TRIG_LSB            12
`define DIAG_ALARM_LSB           8
`define DIAG_DATA_READY          7
`define DIAG_FLASH_TEST          6
`define DIAG_SELF_TEST           5
`define DIAG_PERIOD_VIOL         4
`define DIAG_SPI_FAIL            3
`define DIAG_FLASH_UPD           2
`define DIAG_SUPPLY_HIGH         1
`define DIAG_SUPPLY_LOW          0
`define MISC_SELF_TEST_BIT       8
`define GPIO_LEVEL_LSB           8

// ------------------------------------------------------------
// timing, microseconds as printed (trigger pulse in nanoseconds) and clock rate
// ------------------------------------------------------------
`define CLK_MHZ                  50
`define T_RESTORE_NOCAP_US       980
`define T_RESTORE_CAP_US         7000
`define T_COPY_NOCAP_US          339000
`define T_COPY_CAP_US            509000
`define T_POINTER_US             35
`define T_CLEAR_BUF_US           840
`define T_SOFT_RESET_US          54000
`define T_FLASH_TEST_US          10500
`define T_CLEAR_DIAG_US          35
`define T_FACTORY_US             339000
`define T_SELF_TEST_US           33000
`define T_AUTONULL_US            936000
`define T_TRIG_PULSE_NS          2600
`define TRIG_MIN_CYC             ((`T_TRIG_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

/* sys_ctrl_pkg.sv */
// sys_ctrl_pkg.sv: types shared by the system control register bank
// assumes: nothing beyond the params header
package sys_ctrl_pkg;

    // line function encodings
    typedef enum logic [1:0] {
        LINE_GPIO    = 2'h0,
        LINE_ALARM   = 2'h1,
        LINE_TRIGGER = 2'h2,
        LINE_BUSY    = 2'h3
    } line_func_e;

    // one-cycle events coming from the capture and measurement core
    typedef struct packed {
        logic       capture_start;   // new capture begins
        logic       capture_done;    // capture finished
        logic [2:0] event_axis;      // axis alarm that fired event capture
        logic [3:0] alarm_hit;       // thresholds exceeded during capture
        logic       supply_high;     // supply above upper limit
        logic       supply_low;      // supply below lower limit
        logic       flash_upd_fail;  // nonvolatile update failed
        logic       selftest_fail;   // self-test verdict, valid at end
        logic       checksum_fail;   // flash checksum verdict, valid at end
    } core_status_s;

    // command pulses out to the core
    typedef struct packed {
        logic [15:0] start;          // one-cycle start per command bit
    } core_cmd_s;

endpackage

/* sys_ctrl_regs.sv */
// sys_ctrl_regs.sv: system control registers, command sequencer and digital lines
// assumes: 16-bit register port decoded upstream from the serial interface,
// core supplies status pulses; line pins resolved by the testbench from enables
//
// Operation
// - command bits self-clear after the operation ends
// - bit 13 reloads from flash, timed
// - bit 12 copies to flash, timed
// - bit 8 clears capture buffers, timed
// - bit 5 checksum test, result to flag
// - bit 3 factory restore, timed
// - bit 2 self-test, result in bit 5
// - misc bit 8 enables manual self-test
// - busy line active during capture, writes, commands
// - line config resets to 000f
// - two-bit fields select line function
// - polarity bits except in gpio mode
// - trigger pulse at least 2.6 us, falling edge
// - alarm line active until diag clear
// - gpio direction, level and input readback
// - diag flags sticky, cleared by command or capture
// - diag records trigger axis and thresholds
// - flag transfers during capture
// - flag transfers not multiple of sixteen
// - data ready, checksum, flash update flags
// - supply high and low flags
`timescale 1ns/1ns
`include "sys_ctrl_params.svh"

module sys_ctrl_regs #(
    parameter int unsigned CLK_MHZ     = `CLK_MHZ,        // system clock rate
    parameter logic [15:0] LOT_LOW     = 16'h1234,        // arbitrary value
    parameter logic [15:0] LOT_HIGH    = 16'h5678,        // arbitrary value
    parameter logic [15:0] PRODUCT     = 16'h0a5a,        // arbitrary value
    parameter int unsigned RESTORE_NC  = `T_RESTORE_NOCAP_US * `CLK_MHZ,
    parameter int unsigned RESTORE_C   = `T_RESTORE_CAP_US * `CLK_MHZ,
    parameter int unsigned COPY_NC     = `T_COPY_NOCAP_US * `CLK_MHZ,
    parameter int unsigned COPY_C      = `T_COPY_CAP_US * `CLK_MHZ,
    parameter int unsigned POINTER_CYC = `T_POINTER_US * `CLK_MHZ,
    parameter int unsigned CLRBUF_CYC  = `T_CLEAR_BUF_US * `CLK_MHZ,
    parameter int unsigned SWRST_CYC   = `T_SOFT_RESET_US * `CLK_MHZ,
    parameter int unsigned FTEST_CYC   = `T_FLASH_TEST_US * `CLK_MHZ,
    parameter int unsigned CLRDIAG_CYC = `T_CLEAR_DIAG_US * `CLK_MHZ,
    parameter int unsigned FACTORY_CYC = `T_FACTORY_US * `CLK_MHZ,
    parameter int unsigned STEST_CYC   = `T_SELF_TEST_US * `CLK_MHZ,
    parameter int unsigned NULL_CYC    = `T_AUTONULL_US * `CLK_MHZ
) (
    input  wire logic                       sys_clk_i,        // system clock
    input  wire logic                       rst_n_i,          // sync reset, low
    input  wire logic                       reg_wr_i,         // register write strobe
    input  wire logic                       reg_rd_i,         // register read strobe
    input  wire logic [6:0]                 reg_addr_i,       // byte address
    input  wire logic [15:0]                reg_wdata_i,      // write data
    output logic      [15:0]                reg_rdata_o,      // read data
    input  wire logic                       xfer_end_i,       // serial frame end pulse
    input  wire logic                       xfer_bad_len_i,   // edge count not x16
    input  wire logic                       capture_flash_i,  // flash backup of capture
    input  wire logic                       capturing_i,      // capture in progress
    input  wire sys_ctrl_pkg::core_status_s core_i,           // core status pulses
    output sys_ctrl_pkg::core_cmd_s         cmd_o,            // command start pulses
    output logic                            cmd_busy_o,       // a command is running
    output logic                            trigger_o,        // capture trigger pulse
    output logic                            self_test_en_o,   // manual self-test drive
    input  wire logic [1:0]                 line_in_i,        // line pin levels
    output logic      [1:0]                 line_out_o,       // line drive levels
    output logic      [1:0]                 line_oe_o         // line drive enables
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] line_function_config;   // function and polarity
    logic [15:0] line_gpio_control;      // direction and level
    logic [15:0] misc_control;           // manual self-test
    logic [15:0] diagnostic_flags;       // sticky flags
    logic [15:0] global_command;         // running command bits
    logic [31:0] cmd_count;              // cycles left for running command
    logic        alarm_state;            // alarm line latch
    logic [1:0]  line_sync;              // sampled line inputs
    logic [1:0]  line_prev;              // previous sampled inputs
    logic [15:0] trig_width;             // active time of trigger pulse
    logic        wr_pulse;               // write cycle marker for busy

    // ------------------------------------------------------------
    // command timing lookup
    // ------------------------------------------------------------
    // one function picks the duration for the highest-priority set command bit
    function automatic logic [31:0] cmd_time(input logic [15:0] c, input logic fl);
        logic [31:0] t;
        t = 32'h1;
        if (c[`CMD_RESTORE_FLASH])        t = fl ? RESTORE_C : RESTORE_NC;
        else if (c[`CMD_COPY_FLASH])      t = fl ? COPY_C : COPY_NC;
        else if (c[`CMD_POINTER_RESET])   t = POINTER_CYC;
        else if (c[`CMD_CLEAR_BUFFERS])   t = CLRBUF_CYC;
        else if (c[`CMD_SOFT_RESET])      t = SWRST_CYC;
        else if (c[`CMD_FLASH_TEST])      t = FTEST_CYC;
        else if (c[`CMD_CLEAR_DIAG])      t = CLRDIAG_CYC;
        else if (c[`CMD_FACTORY_RESTORE]) t = FACTORY_CYC;
        else if (c[`CMD_SELF_TEST])       t = STEST_CYC;
        else if (c[`CMD_AUTONULL])        t = NULL_CYC;
        return t;
    endfunction

    // line function field of line n
    function automatic logic [1:0] line_func(input logic [15:0] cfg, input int n);
        return (n == 0) ? cfg[3:2] : cfg[5:4];
    endfunction

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    logic        cmd_write;                                  // write to command reg
    logic [15:0] cmd_accept;                                 // legal bits written
    logic        cmd_end;                                    // running command done
    assign cmd_write  = reg_wr_i && (reg_addr_i == `ADDR_GLOBAL_COMMAND);
    assign cmd_accept = reg_wdata_i & 16'(`CMD_VALID_MASK);
    assign cmd_end    = (global_command != 16'h0) && (cmd_count == 32'h1);

    // new writes are ignored while a command runs; the host must wait anyway
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            global_command <= 16'h0;
            cmd_count      <= 32'h0;
            cmd_o          <= '0;
        end else begin
            cmd_o.start <= 16'h0;
            if (cmd_write && global_command == 16'h0 && cmd_accept != 16'h0) begin
                global_command <= cmd_accept;
                cmd_count      <= cmd_time(cmd_accept, capture_flash_i);
                cmd_o.start    <= cmd_accept;
            end else if (cmd_end) begin
                global_command <= 16'h0;
                cmd_count      <= 32'h0;
            end else if (global_command != 16'h0) begin
                cmd_count <= cmd_count - 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // factory restore brings every writable register to its reset value
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            line_function_config <= `RST_LINE_FUNCTION_CFG;
            line_gpio_control    <= `RST_LINE_GPIO_CONTROL;
            misc_control         <= `RST_MISC_CONTROL;
        end else if (cmd_end && global_command[`CMD_FACTORY_RESTORE]) begin
            line_function_config <= `RST_LINE_FUNCTION_CFG;
            line_gpio_control    <= `RST_LINE_GPIO_CONTROL;
            misc_control         <= `RST_MISC_CONTROL;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADDR_LINE_FUNCTION_CFG) begin
                line_function_config <= {10'h0, reg_wdata_i[5:0]};
            end else if (reg_addr_i == `ADDR_LINE_GPIO_CONTROL) begin
                line_gpio_control <= {6'h0, reg_wdata_i[9:8], 6'h0, reg_wdata_i[1:0]};
            end else if (reg_addr_i == `ADDR_MISC_CONTROL) begin
                misc_control <= {7'h0, reg_wdata_i[8], 8'h0};
            end
        end
    end

    // ------------------------------------------------------------
    // diagnostic flags
    // ------------------------------------------------------------
    logic        diag_clear;                 // clear by command or new capture
    logic [15:0] diag_set;                   // hardware set terms
    assign diag_clear = (cmd_end && global_command[`CMD_CLEAR_DIAG])
                        || core_i.capture_start;
    always_comb begin
        diag_set = 16'h0;
        diag_set[14:12] = core_i.event_axis;
        diag_set[11:8]  = core_i.alarm_hit;
        diag_set[`DIAG_DATA_READY]  = core_i.capture_done;
        diag_set[`DIAG_FLASH_TEST]  = cmd_end && global_command[`CMD_FLASH_TEST]
                                      && core_i.checksum_fail;
        diag_set[`DIAG_SELF_TEST]   = cmd_end && global_command[`CMD_SELF_TEST]
                                      && core_i.selftest_fail;
        diag_set[`DIAG_PERIOD_VIOL] = xfer_end_i && capturing_i;
        diag_set[`DIAG_SPI_FAIL]    = xfer_end_i && xfer_bad_len_i;
        diag_set[`DIAG_FLASH_UPD]   = core_i.flash_upd_fail;
        diag_set[`DIAG_SUPPLY_HIGH] = core_i.supply_high;
        diag_set[`DIAG_SUPPLY_LOW]  = core_i.supply_low;
    end

    // set wins over clear so an event in the clearing cycle is kept
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            diagnostic_flags <= `RST_DIAGNOSTIC_FLAGS;
        end else if (diag_clear) begin
            diagnostic_flags <= diag_set;
        end else begin
            diagnostic_flags <= diagnostic_flags | diag_set;
        end
    end

    // alarm latch follows threshold flags, dropped by diag clear
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            alarm_state <= 1'b0;
        end else if (|core_i.alarm_hit) begin
            alarm_state <= 1'b1;
        end else if (diag_clear) begin
            alarm_state <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // trigger input detection
    // ------------------------------------------------------------
    // inputs are synchronous already; one stage keeps history for edges
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            line_sync <= 2'h0;
            line_prev <= 2'h0;
        end else begin
            line_sync <= line_in_i;
            line_prev <= line_sync;
        end
    end

    logic [1:0] active_lvl;                  // polarity corrected inputs
    logic [1:0] is_trig;                     // line set as trigger
    assign active_lvl = ~(line_sync ^ line_function_config[1:0]);
    for (genvar n = 0; n < 2; n++) begin : g_trig
        assign is_trig[n] = line_func(line_function_config, n) == 2'(sys_ctrl_pkg::LINE_TRIGGER);
    end

    // width counts the active phase of the first trigger-configured line
    logic trig_lvl;                                                    // chosen line level
    logic trig_prev;                                                   // its previous level
    assign trig_lvl  = is_trig[0] ? active_lvl[0] : (is_trig[1] & active_lvl[1]);
    assign trig_prev = is_trig[0] ? ~(line_prev[0] ^ line_function_config[0])
                                  : (is_trig[1] & ~(line_prev[1] ^ line_function_config[1]));
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            trig_width <= 16'h0;
            trigger_o  <= 1'b0;
        end else begin
            trigger_o <= 1'b0;
            if (trig_lvl) begin
                if (trig_width != 16'hffff) trig_width <= trig_width + 16'h1;
            end else begin
                trig_width <= 16'h0;
                if (trig_prev && trig_width >= 16'(`TRIG_MIN_CYC))
                    trigger_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // line drivers
    // ------------------------------------------------------------
    // write cycles count as busy for one cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) wr_pulse <= 1'b0;
        else          wr_pulse <= reg_wr_i;
    end

    logic busy_lvl;                                                    // busy condition
    assign busy_lvl = capturing_i || wr_pulse || (global_command != 16'h0);

    for (genvar n = 0; n < 2; n++) begin : g_line
        always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
                line_out_o[n] <= 1'b0;
                line_oe_o[n]  <= 1'b0;
            end else begin
                case (line_func(line_function_config, n))
                    2'(sys_ctrl_pkg::LINE_GPIO): begin
                        line_oe_o[n]  <= line_gpio_control[n];
                        line_out_o[n] <= line_gpio_control[`GPIO_LEVEL_LSB + n];
                    end
                    2'(sys_ctrl_pkg::LINE_ALARM): begin
                        line_oe_o[n]  <= 1'b1;
                        line_out_o[n] <= ~(alarm_state ^ line_function_config[n]);
                    end
                    2'(sys_ctrl_pkg::LINE_BUSY): begin
                        line_oe_o[n]  <= 1'b1;
                        line_out_o[n] <= ~(busy_lvl ^ line_function_config[n]);
                    end
                    default: begin
                        line_oe_o[n]  <= 1'b0;
                        line_out_o[n] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs and read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cmd_busy_o     <= 1'b0;
            self_test_en_o <= 1'b0;
        end else begin
            cmd_busy_o     <= (global_command != 16'h0);
            self_test_en_o <= misc_control[`MISC_SELF_TEST_BIT];
        end
    end

    // read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `ADDR_LINE_FUNCTION_CFG)      reg_rdata_o <= line_function_config;
            else if (reg_addr_i == `ADDR_LINE_GPIO_CONTROL)
                reg_rdata_o <= {line_gpio_control[15:8], 6'h0, line_sync};
            else if (reg_addr_i == `ADDR_MISC_CONTROL)      reg_rdata_o <= misc_control;
            else if (reg_addr_i == `ADDR_DIAGNOSTIC_FLAGS)  reg_rdata_o <= diagnostic_flags;
            else if (reg_addr_i == `ADDR_GLOBAL_COMMAND)    reg_rdata_o <= global_command;
            else if (reg_addr_i == `ADDR_LOT_CODE_LOW)      reg_rdata_o <= LOT_LOW;
            else if (reg_addr_i == `ADDR_LOT_CODE_HIGH)     reg_rdata_o <= LOT_HIGH;
            else if (reg_addr_i == `ADDR_PRODUCT_CODE)      reg_rdata_o <= PRODUCT;
            else                                            reg_rdata_o <= 16'h0;
        end
    end

endmodule

/* sys_ctrl_regs_props.sv */
// sys_ctrl_regs_props.sv: port checker for the system control register bank
// assumes: command durations shortened to 20 cycles by the testbench
`timescale 1ns/1ns
module sys_ctrl_regs_props (
    input wire logic                    sys_clk_i,    // clock
    input wire logic                    rst_n_i,      // sync reset, low
    input wire logic                    reg_wr_i,     // write strobe
    input wire logic                    reg_rd_i,     // read strobe
    input wire logic [6:0]              reg_addr_i,   // byte address
    input wire logic [15:0]             reg_wdata_i,  // write data
    input wire logic [15:0]             reg_rdata_o,  // read data
    input wire sys_ctrl_pkg::core_cmd_s cmd_o,        // command pulses
    input wire logic                    cmd_busy_o,   // command running
    input wire logic                    trigger_o     // trigger pulse
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // an idle command write; the device also accepts one in the cycle after a command ends, while busy is still high
    sequence s_cmd_wr;
        reg_wr_i && reg_addr_i == 7'h3e && !cmd_busy_o && cmd_o.start == 16'h0;
    endsequence
    a_cmd_start_pulse: assert property (s_cmd_wr |=> cmd_o.start == ($past(reg_wdata_i) & 16'h3dbf))
        else $error("command pulse does not match write");
    a_reserved_masked: assert property ((cmd_o.start & 16'hc240) == 16'h0)
        else $error("reserved command bit started");
    a_start_one_cycle: assert property (|cmd_o.start |=> cmd_o.start == 16'h0)
        else $error("command pulse longer than one cycle");
    a_busy_follows: assert property (|cmd_o.start |=> cmd_busy_o)
        else $error("busy missing after command start");
    a_busy_cause: assert property ($rose(cmd_busy_o) |-> $past(|cmd_o.start))
        else $error("busy without command");
    a_busy_ends: assert property ($rose(cmd_busy_o) |-> ##[1:40] !cmd_busy_o)
        else $error("command never self-cleared");
    a_trig_pulse: assert property (trigger_o |=> !trigger_o)
        else $error("trigger pulse too long");
    a_rdata_stands: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
        else $error("read data changed without read");
endmodule
bind sys_ctrl_regs sys_ctrl_regs_props u_props (.sys_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .cmd_o, .cmd_busy_o, .trigger_o);
